/* File: core/gsp_fifo.sv */
`default_nettype none
module gsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      count <= '0;
    else if (push && !pop)
      count <= count + 1'b1;
    else if (pop && !push)
      count <= count - 1'b1;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  count_bound_a: assert property (@(posedge clk) disable iff (rst)
    count <= FULL)
    else $error("buffer count beyond depth");
endmodule // gsp_fifo
`default_nettype wire

/* File: core/gsp_pkg.sv */
`default_nettype none
package gsp_pkg;
  // ---------------------------------------------------------------
  // chain shape and reset values
  // ---------------------------------------------------------------
  localparam int          STAGES      = 8;
  localparam int          BUF_DEPTH   = 2;
  localparam logic [7:0]  STAGE_RESET = 8'h00;
  localparam logic        CLK_RESET   = 1'b0;
  // ---------------------------------------------------------------
  // word handed to the receiver after each shift that finds the buffer not full
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [STAGES-1:0] stages;
  } gsp_word_t;
endpackage
`default_nettype wire

/* File: core/gsp_shifter.sv */
`default_nettype none
module gsp_shifter (
  // system
  input  wire logic        CLK,
  input  wire logic        RST,
  // host pins
  input  wire logic        SER_A,
  input  wire logic        SER_B,
  input  wire logic        SHIFT_CLK,
  input  wire logic        DIRECT_WIPE_LOW,
  // parallel outputs, bit 0 is stage one
  output logic [7:0]       PAR_OUT,
  output logic             STAGE_ONE_OUT,
  output logic             STAGE_SEVEN_OUT,
  output logic             STAGE_EIGHT_OUT,
  // word stream, one word per shift taken while SHIFT_READY is high
  output logic             SHIFT_READY,
  output logic             WORD_VALID,
  input  wire logic        WORD_READY,
  output logic [7:0]       WORD_DATA
);
  localparam int N = gsp_pkg::STAGES;

  initial
  begin
    if (N != 8)
      $error("chain must have eight stages");
  end

  logic [N-1:0]       stages;
  logic [N-1:0]       next_stages;
  logic               prev_clk;
  logic               rise;
  logic               gated;
  logic               shift;
  logic [3:0]         wipe_cycles;
  gsp_pkg::gsp_word_t push_word;
  gsp_pkg::gsp_word_t pop_word;

  // ---------------------------------------------------------------
  // serial gate, shared by logic and checks
  // ---------------------------------------------------------------
  function automatic logic gate_bit(input logic a, input logic b);
    return a & b;
  endfunction

  // ---------------------------------------------------------------
  // edge detect and input gate
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      prev_clk <= gsp_pkg::CLK_RESET;
    else
      prev_clk <= SHIFT_CLK;
  end

  assign rise  = SHIFT_CLK && !prev_clk;
  assign gated = gate_bit(SER_A, SER_B);
  assign shift = rise && DIRECT_WIPE_LOW;

  // ---------------------------------------------------------------
  // stage chain
  // ---------------------------------------------------------------
  always_comb
  begin
    next_stages = {stages[N-2:0], gated};
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      stages <= gsp_pkg::STAGE_RESET;
    else if (!DIRECT_WIPE_LOW)
      stages <= gsp_pkg::STAGE_RESET;
    else if (shift)
      stages <= next_stages;
  end

  // wipe acts on the pins before the next clock edge
  assign PAR_OUT         = DIRECT_WIPE_LOW ? stages : '0;
  assign STAGE_ONE_OUT   = PAR_OUT[0];
  assign STAGE_SEVEN_OUT = PAR_OUT[6];
  assign STAGE_EIGHT_OUT = PAR_OUT[7];

  // ---------------------------------------------------------------
  // wipe length, for the hold check
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      wipe_cycles <= 4'h0;
    else if (DIRECT_WIPE_LOW)
      wipe_cycles <= 4'h0;
    else if (wipe_cycles != 4'hf)
      wipe_cycles <= wipe_cycles + 4'h1;
  end

  // ---------------------------------------------------------------
  // word buffer
  // ---------------------------------------------------------------
  assign push_word.stages = next_stages;

  gsp_fifo #(
    .WIDTH (N),
    .DEPTH (gsp_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (shift),
    .in_ready  (SHIFT_READY),
    .in_data   (push_word),
    .out_valid (WORD_VALID),
    .out_ready (WORD_READY),
    .out_data  (pop_word)
  );

  assign WORD_DATA = pop_word.stages;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wipe_zeroes_pins_a: assert property (
    !DIRECT_WIPE_LOW |-> PAR_OUT == 8'h00)
    else $error("pins not zero during wipe");

  wipe_blocks_edges_a: assert property (
    !DIRECT_WIPE_LOW && rise |=> stages == 8'h00)
    else $error("edge shifted during wipe");

  first_stage_load_a: assert property (
    shift |=> stages[0] == $past(gate_bit(SER_A, SER_B)))
    else $error("stage one not the gated bit");

  chain_moves_one_a: assert property (
    shift |=> stages[7:1] == $past(stages[6:0]))
    else $error("pattern not moved one place");

  hold_without_edge_a: assert property (
    DIRECT_WIPE_LOW && !rise ##1 DIRECT_WIPE_LOW |-> $stable(stages))
    else $error("stages changed without edge");

  last_stage_lost_a: assert property (
    shift && stages[6:0] == 7'h00 && !gated |=> PAR_OUT == 8'h00)
    else $error("old stage eight still visible");

  word_pushed_a: assert property (
    shift && SHIFT_READY |=> WORD_VALID)
    else $error("shifted word not buffered");

  word_held_a: assert property (
    WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA))
    else $error("word lost under stall");

  pins_follow_stages_a: assert property (
    DIRECT_WIPE_LOW |-> PAR_OUT == stages)
    else $error("pins differ from stages");

  wipe_clears_stages_a: assert property (
    !DIRECT_WIPE_LOW |=> stages == 8'h00)
    else $error("stages not cleared by wipe");

  hold_when_idle_a: assert property (
    DIRECT_WIPE_LOW && !shift |=> stages == $past(stages))
    else $error("stages changed while idle");

  word_matches_a: assert property (
    shift && SHIFT_READY && !WORD_VALID |=> WORD_DATA == stages)
    else $error("buffered word differs from stages");

  fall_holds_a: assert property (
    $fell(SHIFT_CLK) && DIRECT_WIPE_LOW |=> $stable(stages))
    else $error("falling edge changed stages");

  eighth_takes_seventh_a: assert property (
    shift |=> stages[7] == $past(stages[6]))
    else $error("stage eight kept old value");

  full_means_valid_a: assert property (
    !SHIFT_READY |-> WORD_VALID)
    else $error("full buffer shows no word");

  rise_once_a: assert property (
    rise |=> !rise)
    else $error("one edge seen twice");

  no_push_wiped_a: assert property (
    !DIRECT_WIPE_LOW |-> !shift)
    else $error("shift taken during wipe");

  wipe_held_zero_a: assert property (
    wipe_cycles != 4'h0 |-> stages == 8'h00)
    else $error("stages nonzero during wipe");

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  shift_seen_c: cover property (shift ##[1:4] WORD_VALID);
  wipe_seen_c: cover property (!DIRECT_WIPE_LOW && rise);
  buffer_full_c: cover property (!SHIFT_READY && WORD_VALID);
  ones_fill_c: cover property (PAR_OUT == 8'hff);
  wipe_release_c: cover property ($rose(DIRECT_WIPE_LOW));
endmodule // gsp_shifter
`default_nettype wire

/* File: tb/gsp_host.sv */
`default_nettype none
module gsp_host (
  // host pins
  input  wire logic clk,
  output logic      ser_a,
  output logic      ser_b,
  output logic      shift_clk,
  output logic      wipe_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ser_a = 1'b0;
    ser_b = 1'b0;
    shift_clk = 1'b0;
    wipe_low = 1'b1;
  end
  // ------
  // one shift: data with the rise, then scrambled
  // ------
  task automatic shift(input logic a, input logic b);
    @(posedge clk);
    ser_a     <= a;
    ser_b     <= b;
    shift_clk <= 1'b1;
    @(posedge clk);
    shift_clk <= 1'b0;
    ser_a     <= ~a;
    ser_b     <= ~b;
  endtask
  task automatic wipe(input logic v);
    @(posedge clk);
    wipe_low <= v;
  endtask
endmodule // gsp_host
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ser_a, ser_b, shift_clk, wipe_low, word_ready = 1'b1;
  logic       s1, s7, s8, shift_ready, word_valid;
  logic [7:0] par_out, word_data, exp;
  int         failures = 0;
  int         num_checks = 0;
  always #4 clk = ~clk;
  gsp_host gsp_host_i (.clk(clk), .ser_a(ser_a), .ser_b(ser_b),
    .shift_clk(shift_clk), .wipe_low(wipe_low));
  gsp_shifter gsp_shifter_i (.CLK(clk), .RST(rst), .SER_A(ser_a),
    .SER_B(ser_b), .SHIFT_CLK(shift_clk), .DIRECT_WIPE_LOW(wipe_low),
    .PAR_OUT(par_out), .STAGE_ONE_OUT(s1), .STAGE_SEVEN_OUT(s7),
    .STAGE_EIGHT_OUT(s8), .SHIFT_READY(shift_ready),
    .WORD_VALID(word_valid), .WORD_READY(word_ready),
    .WORD_DATA(word_data));
  // ------
  // compares and verdict
  // ------
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk1(input logic got, input logic want);
    chk8({7'h00, got}, {7'h00, want});
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_shift;
    logic [19:0] pat;
    pat = 20'hf9e37;
    for (int i = 0; i < 10; i++)
    begin
      gsp_host_i.shift(pat[2*i+1], pat[2*i]);
      exp = {exp[6:0], pat[2*i+1] & pat[2*i]};
      @(negedge clk);
      chk8(par_out, exp);
      chk1(s1, exp[0]);
      chk1(s7, exp[6]);
      chk1(s8, exp[7]);
    end
    repeat (4) @(negedge clk);
    chk8(par_out, exp);
  endtask
  task automatic t_wipe;
    gsp_host_i.shift(1'b1, 1'b1);
    @(negedge clk);
    chk1(s1, 1'b1);
    gsp_host_i.wipe(1'b0);
    @(negedge clk);
    chk8(par_out, 8'h00);
    fork
      gsp_host_i.shift(1'b1, 1'b1);
      begin
        @(posedge clk);
        gsp_host_i.wipe(1'b1);
      end
    join
    repeat (3) @(negedge clk);
    chk8(par_out, 8'h00);
    chk1(word_valid, 1'b0);
  endtask
  task automatic t_buf;
    @(posedge clk);
    word_ready <= 1'b0;
    gsp_host_i.shift(1'b1, 1'b1);
    gsp_host_i.shift(1'b0, 1'b1);
    @(negedge clk);
    chk1(shift_ready, 1'b0);
    chk8(word_data, 8'h01);
    chk8(par_out, 8'h02);
    @(posedge clk);
    word_ready <= 1'b1;
    repeat (2) @(negedge clk);
    chk8(word_data, 8'h02);
    @(negedge clk);
    chk1(word_valid, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    exp = 8'h00;
    @(negedge clk);
    chk8(par_out, 8'h00);
    chk1(word_valid, 1'b0);
    t_shift;
    t_wipe;
    t_buf;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
